// ---- logic/uer_ranger.sv ----
`timescale 1ns/1ps
module uer_ranger
    import uer_pkg::*;
#(
    parameter int PING_CYCLES = PING_CYC,
    parameter int TICK_CYCLES = TICK_CYC,
    parameter int PAUSE_CYCLES = PAUSE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Front end pins
    output logic tx_enable,
    input wire logic echo_detect_n,
    // Calibration, signed count offset
    input wire logic [15:0] cal_offset,
    // Result
    output logic [15:0] echo_count,
    output logic [15:0] round_trip_in,
    output logic [15:0] one_way_in,
    output logic result_valid,
    output logic timed_out
);
    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    logic [2:0] det_sync;
    logic det_state;
    // Change accepted only once stages two and three agree
    wire det_agree = (det_sync[1] == det_sync[2]);
    wire next_det = det_agree ? det_sync[2] : det_state;
    wire det_rise = next_det && !det_state;
    wire det_fall = !next_det && det_state;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            det_sync <= 3'h7;
            det_state <= 1'b1;
        end else begin
            det_sync <= {det_sync[1:0], echo_detect_n};
            det_state <= next_det;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_PING, S_ARM, S_TIME, S_DONE, S_PAUSE
    } uer_state_t;
    uer_state_t state, next_state;
    logic [31:0] timer;
    logic [CNT_W-1:0] count;
    logic [31:0] next_timer;
    logic [CNT_W-1:0] next_count;
    logic fail, next_fail;

    wire tick = (timer == 32'(TICK_CYCLES - 1));
    // Overflow of the counter ends either wait
    wire cnt_full = (count == {CNT_W{1'b1}});
    always_comb begin
        next_state = state;
        next_timer = timer + 32'h1;
        next_count = count;
        next_fail = fail;
        case (state)
            S_PING: begin
                if (timer == 32'(PING_CYCLES - 1)) begin
                    next_state = S_ARM;
                    next_timer = 32'h0;
                    next_count = CNT_RST;
                    next_fail = 1'b0;
                end
            end
            S_ARM: begin
                if (tick) begin
                    next_timer = 32'h0;
                    next_count = count + 16'h1;
                end
                if (det_rise) begin
                    next_state = S_TIME;
                    next_timer = 32'h0;
                    next_count = CNT_RST;
                end else if (tick && cnt_full) begin
                    next_state = S_DONE;
                    next_fail = 1'b1;
                end
            end
            S_TIME: begin
                if (tick) begin
                    next_timer = 32'h0;
                    next_count = count + 16'h1;
                end
                if (det_fall) begin
                    next_state = S_DONE;
                    next_count = count;
                end else if (tick && cnt_full) begin
                    next_state = S_DONE;
                    next_fail = 1'b1;
                end
            end
            S_DONE: begin
                next_state = S_PAUSE;
                next_timer = 32'h0;
            end
            S_PAUSE: begin
                if (timer == 32'(PAUSE_CYCLES - 1)) begin
                    next_state = S_PING;
                    next_timer = 32'h0;
                end
            end
            default: begin
                next_state = S_PAUSE;
                next_timer = 32'h0;
            end
        endcase
    end

    // Reset lands in the pause so the line is low before the first ping
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_PAUSE;
            timer <= 32'h0;
            count <= CNT_RST;
            fail <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            count <= next_count;
            fail <= next_fail;
        end
    end

    // ------------------------------------------------------------
    // Conversion and outputs
    // ------------------------------------------------------------
    wire [CNT_W-1:0] rep_count = fail ? CNT_RST : count;
    // Signed sum, so a negative offset on a short count cannot wrap
    wire signed [15:0] offset_s = signed'(cal_offset);
    wire signed [31:0] sum = signed'(32'(rep_count)) + 32'(offset_s);
    wire signed [31:0] trip = (sum * DIST_MUL) / DIST_DIV;
    wire next_tx = (next_state == S_PING);
    wire done = (state == S_DONE);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_enable <= 1'b0;
            echo_count <= CNT_RST;
            round_trip_in <= 16'h0000;
            one_way_in <= 16'h0000;
            result_valid <= 1'b0;
            timed_out <= 1'b0;
        end else begin
            tx_enable <= next_tx;
            result_valid <= done;
            if (done) begin
                echo_count <= rep_count;
                round_trip_in <= trip[15:0];
                one_way_in <= trip[16:1];
                timed_out <= fail;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Pulse length counter; a repetition cannot span a full ping
    logic [31:0] tx_run;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_run <= 32'h0;
        end else begin
            tx_run <= tx_enable ? tx_run + 32'h1 : 32'h0;
        end
    end

    a_ping_width: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(tx_enable) |-> tx_enable [*8])
        else $error("transmit pulse too short");
    a_ping_length: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(tx_enable) |-> tx_run == 32'(PING_CYCLES))
        else $error("transmit pulse length wrong");
    a_tx_only_ping: assert property (@(posedge clk) disable iff (!rst_n)
        tx_enable |-> (state == S_PING))
        else $error("transmit enable outside ping");
    a_timeout_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (result_valid && timed_out) |-> echo_count == 16'h0000)
        else $error("timeout did not report zero");
    a_rise_starts: assert property (@(posedge clk) disable iff (!rst_n)
        (state == S_ARM && det_rise) |=> (state == S_TIME && count == CNT_RST))
        else $error("rising edge did not start timing");
    a_fall_stops: assert property (@(posedge clk) disable iff (!rst_n)
        (state == S_TIME && det_fall) |=> state == S_DONE)
        else $error("falling edge did not stop timing");
    a_report_once: assert property (@(posedge clk) disable iff (!rst_n)
        result_valid |=> !result_valid ##1 !tx_enable)
        else $error("report not a single pulse");
    a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
        (state == S_TIME && !det_fall && !cnt_full)
        |=> count == $past(count) + 16'($past(tick)))
        else $error("count did not follow the tick");
    a_no_tx_pause: assert property (@(posedge clk) disable iff (!rst_n)
        (state == S_PAUSE) |-> !tx_enable)
        else $error("transmit during pause");
    a_oneway_half: assert property (@(posedge clk) disable iff (!rst_n)
        result_valid |-> one_way_in == {round_trip_in[15], round_trip_in[15:1]})
        else $error("one way not half of round trip");
    c_echo: cover property (@(posedge clk) disable iff (!rst_n)
        result_valid && !timed_out);
    c_timeout: cover property (@(posedge clk) disable iff (!rst_n)
        result_valid && timed_out);
    c_repeat: cover property (@(posedge clk) disable iff (!rst_n)
        state == S_PAUSE ##1 state == S_PING);
    c_rise_arm: cover property (@(posedge clk) disable iff (!rst_n)
        state == S_ARM && det_rise);
endmodule

// ---- logic/uer_pkg.sv ----
package uer_pkg;
    // Timing, in the units printed
    localparam int CLK_HZ = 20000000;
    localparam int PING_US = 500;
    localparam int TICK_US = 10;
    localparam int PAUSE_MS = 500;
    // Cycle counts derived from the clock rate
    localparam int PING_CYC = PING_US * (CLK_HZ / 1000000);
    localparam int TICK_CYC = TICK_US * (CLK_HZ / 1000000);
    localparam int PAUSE_CYC = PAUSE_MS * (CLK_HZ / 1000);
    // Count layout and distance conversion
    localparam int CNT_W = 16;
    localparam int DIST_MUL = 10;
    localparam int DIST_DIV = 74;
    localparam logic [15:0] CNT_RST = 16'h0000;
endpackage

// ---- test/uer_echo_model.sv ----
`timescale 1ns/1ps
module uer_echo_model (
    // Clock and scenario control
    input wire logic clk,
    input wire logic silent,
    input wire logic [15:0] gap,
    // Front end
    input wire logic tx_enable,
    output logic echo_detect_n
);
    int st = 0;
    int n = 0;
    // Pull-up: idle detector output reads high
    initial echo_detect_n = 1'b1;
    always @(posedge clk) begin
        n = n + 1;
        case (st)
            0: if (tx_enable && !silent) begin
                echo_detect_n <= 1'b0;
                st = 1;
            end
            1: if (!tx_enable) begin
                st = 2;
                n = 0;
            end
            // Decoder output stretch after the burst
            2: if (n == 6) begin
                echo_detect_n <= 1'b1;
                st = 3;
                n = 0;
            end
            3: if (n == gap) begin
                echo_detect_n <= 1'b0;
                st = 4;
                n = 0;
            end
            4: if (n == 5) begin
                echo_detect_n <= 1'b1;
                st = 0;
            end
            default: st = 0;
        endcase
    end
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import uer_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic silent = 1'b0;
    logic [15:0] gap = 16'h0020;
    logic [15:0] cal_offset = 16'h0000;
    logic tx_enable, echo_detect_n, result_valid, timed_out, tx_prev;
    logic [15:0] echo_count, round_trip_in, one_way_in;
    int bad_count = 0;
    int samples_checked = 0;
    bit [31:0] seed = 38898;
    int hi_len = 0;
    int p_len = 0;
    bit seen_res = 0;
    int off, g, rt;
    uer_ranger #(.PING_CYCLES(20), .TICK_CYCLES(1), .PAUSE_CYCLES(50))
        uer_ranger_i (.clk(clk), .rst_n(rst_n), .tx_enable(tx_enable),
        .echo_detect_n(echo_detect_n), .cal_offset(cal_offset),
        .echo_count(echo_count), .round_trip_in(round_trip_in),
        .one_way_in(one_way_in), .result_valid(result_valid),
        .timed_out(timed_out));
    uer_echo_model uer_echo_model_i (.clk(clk), .silent(silent), .gap(gap),
        .tx_enable(tx_enable), .echo_detect_n(echo_detect_n));
    initial forever #25 clk = ~clk;
    function automatic int xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'(seed & 32'h7FFF);
    endfunction
    task automatic check(string what, int lo, int hi, logic [31:0] seen);
        samples_checked++;
        if (seen >= lo && seen <= hi) begin
        end else begin
            bad_count++;
            $display("ERROR %s expected %0d..%0d seen %0d",
                what, lo, hi, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wait_result(int limit);
        int i;
        @(negedge clk);
        for (i = 0; i < limit && result_valid !== 1'b1; i++) @(negedge clk);
        check("result_valid", 1, 1, {31'h0, result_valid});
    endtask
    // Ping width and pause between result and next ping
    always @(negedge clk) begin
        // Length is taken before the counter clears on the falling sample
        if (tx_prev && !tx_enable) check("ping_len", 20, 20, hi_len);
        hi_len = tx_enable ? hi_len + 1 : 0;
        p_len = result_valid ? 0 : p_len + 1;
        if (result_valid === 1'b1) seen_res = 1;
        if (tx_enable && !tx_prev && seen_res) begin
            check("pause", 50, 52, p_len);
        end
        tx_prev <= tx_enable;
    end
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (19) @(negedge clk);
        check("tx_rst", 0, 0, {31'h0, tx_enable});
        check("cnt_rst", 0, 0, {16'h0, echo_count});
        @(negedge clk);
        rst_n = 1'b1;
        repeat (6) begin
            off = xs() % 40 - 8;
            cal_offset = 16'(off);
            g = gap;
            wait_result(3000);
            check("echo_count", g - 1, g + 1, {16'h0, echo_count});
            check("timed_out", 0, 0, {31'h0, timed_out});
            rt = (int'(echo_count) + off) * 10 / 74;
            check("round_trip", rt, rt, {16'h0, round_trip_in});
            check("one_way", rt / 2, rt / 2, {16'h0, one_way_in});
            gap = 16'(10 + xs() % 300);
        end
        // Calibrate on a known 20 inch range, then measure it again
        gap = 16'h0100;
        wait_result(3000);
        off = 20 * 2 * 7375 / 1000 - int'(echo_count);
        cal_offset = 16'(off);
        wait_result(3000);
        check("cal_trip", 38, 40, {16'h0, round_trip_in});
        silent = 1'b1;
        wait_result(70000);
        check("to_count", 0, 0, {16'h0, echo_count});
        check("to_flag", 1, 1, {31'h0, timed_out});
        report_and_stop();
    end
endmodule
